// file: common/rtc_alarm_cfg.svh
// Register offsets, field positions, reset values and timing counts of the alarm block
`ifndef RTC_ALARM_CFG_SVH
`define RTC_ALARM_CFG_SVH

// ==========================================================================
// Register byte offsets
`define OFS_ALARM_CONFIG_REPEAT  12'h000
`define OFS_ALARM_VALUE_WINDOW   12'h004
`define OFS_CONFIG_CALIBRATION   12'h008
`define OFS_TIME_MONTH_DAY       12'h00C
`define OFS_TIME_WEEKDAY_HOUR    12'h010
`define OFS_TIME_MINUTE_SECOND   12'h014
`define OFS_STATUS               12'h018

// ==========================================================================
// Alarm configuration fields
`define BIT_ALARM_ON     15
`define BIT_CHIME        14
`define POS_INTERVAL     10
`define POS_POINTER      8
`define POS_REPEAT       0

// ==========================================================================
// Calibration register fields
`define BIT_WRITE_UNLOCK 15
`define BIT_TIMER_ON     14
`define POS_CAL          0

// ==========================================================================
// Value masks of implemented bits
`define MASK_MONTH_DAY      16'h1F3F
`define MASK_WEEKDAY_HOUR   16'h073F
`define MASK_MINUTE_SECOND  16'h7F7F

// ==========================================================================
// Reset values
`define RST_CONFIG_REPEAT   16'h0000
`define RST_CALIBRATION     16'h0000
`define RST_ALARM_VALUE     16'h0000

// ==========================================================================
// Timing
`define RTC_TICKS_PER_HALF_SEC  16384
`define CAL_STEP_PULSES         4

`endif

// file: common/rtc_alarm_pkg.sv
// Types shared by the alarm and calibration block
package rtc_alarm_pkg;

    typedef enum logic [3:0] {
        iv_half_sec, iv_second, iv_ten_sec, iv_minute, iv_ten_min,
        iv_hour, iv_day, iv_week, iv_month, iv_year,
        iv_res_a, iv_res_b, iv_res_c, iv_res_d, iv_res_e, iv_res_f
    } interval_e;

    typedef enum logic [1:0] {
        ptr_min_sec, ptr_wd_hour, ptr_month_day, ptr_none
    } value_ptr_e;

endpackage

// file: design/alarm_match.sv
// Alarm digit comparator selected by the interval code
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module alarm_match
    import rtc_alarm_pkg::*;
(
    // Selection
    input  wire logic [3:0]  interval,
    // Alarm digits
    input  wire logic [15:0] al_month_day,
    input  wire logic [15:0] al_wd_hour,
    input  wire logic [15:0] al_min_sec,
    // Current digits
    input  wire logic [15:0] tm_month_day,
    input  wire logic [15:0] tm_wd_hour,
    input  wire logic [15:0] tm_min_sec,
    // Result
    output logic             match
);

    logic sec1, sec10, min1, min10, hr, wd, dy, mo;

    assign sec1  = al_min_sec[3:0]    == tm_min_sec[3:0];
    assign sec10 = al_min_sec[6:4]    == tm_min_sec[6:4];
    assign min1  = al_min_sec[11:8]   == tm_min_sec[11:8];
    assign min10 = al_min_sec[14:12]  == tm_min_sec[14:12];
    assign hr    = al_wd_hour[5:0]    == tm_wd_hour[5:0];
    assign wd    = al_wd_hour[10:8]   == tm_wd_hour[10:8];
    assign dy    = al_month_day[5:0]  == tm_month_day[5:0];
    assign mo    = al_month_day[12:8] == tm_month_day[12:8];

    // Each wider interval from iv_ten_sec up adds digits, but iv_month compares the day in place of the weekday; reserved codes never match
    always_comb begin
        unique case (interval_e'(interval))
            iv_half_sec: match = 1'b1;
            iv_second:   match = 1'b1;
            iv_ten_sec:  match = sec1;
            iv_minute:   match = sec1 & sec10;
            iv_ten_min:  match = sec1 & sec10 & min1;
            iv_hour:     match = sec1 & sec10 & min1 & min10;
            iv_day:      match = sec1 & sec10 & min1 & min10 & hr;
            iv_week:     match = sec1 & sec10 & min1 & min10 & hr & wd;
            iv_month:    match = sec1 & sec10 & min1 & min10 & hr & dy;
            iv_year:     match = sec1 & sec10 & min1 & min10 & hr & dy & mo;
            default:     match = 1'b0;
        endcase
    end

endmodule

// file: design/rtc_alarm_calibration.sv
// Alarm compare, repeat, pulse output and minute calibration with APB registers
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_calibration
    import rtc_alarm_pkg::*;
#(
    parameter int TICKS_PER_HALF_SEC = `RTC_TICKS_PER_HALF_SEC
)(
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Time base from the timekeeping counters (same clock)
    input  wire logic        rtc_tick,
    input  wire logic        half_sec_tick,
    input  wire logic        minute_rollover,
    input  wire logic        rollover_window,
    input  wire logic [15:0] time_month_day,
    input  wire logic [15:0] time_weekday_hour,
    input  wire logic [15:0] time_minute_second,
    // Calibration output to the timer counter
    output logic             cal_apply,
    output logic signed [10:0] cal_pulses,
    // Alarm outputs
    output logic             alarm_event,
    output logic             alarm_pulse
);

    // ======================================================================
    // Register state
    logic [15:0] cfg_ff, nxt_cfg;
    logic [15:0] cal_ff, nxt_cal;
    logic [15:0] al_md_ff, nxt_al_md;
    logic [15:0] al_wh_ff, nxt_al_wh;
    logic [15:0] al_ms_ff, nxt_al_ms;
    logic        half_ff, nxt_half;
    logic        event_ff, nxt_event;
    logic        pulse_ff, nxt_pulse;
    logic        cal_apply_ff, nxt_cal_apply;
    logic signed [10:0] cal_pulses_ff, nxt_cal_pulses;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        match;

    logic wr_access, rd_access, window_high;
    logic [1:0] ptr;

    // Zero-wait slave: the access phase completes in its first cycle
    assign wr_access   = psel & penable & pwrite;
    assign rd_access   = psel & penable & ~pwrite;
    assign ptr         = cfg_ff[`POS_POINTER +: 2];
    assign window_high = psel & penable & (paddr == `OFS_ALARM_VALUE_WINDOW) & 
                         (pwrite ? pstrb[3] : 1'b1);

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a == `OFS_ALARM_CONFIG_REPEAT) || (a == `OFS_ALARM_VALUE_WINDOW) ||
                     (a == `OFS_CONFIG_CALIBRATION)  || (a == `OFS_TIME_MONTH_DAY) ||
                     (a == `OFS_TIME_WEEKDAY_HOUR)   || (a == `OFS_TIME_MINUTE_SECOND) ||
                     (a == `OFS_STATUS);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] st);
        merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ======================================================================
    // Comparator
    alarm_match u_match (
        .interval     (cfg_ff[`POS_INTERVAL +: 4]),
        .al_month_day (al_md_ff),
        .al_wd_hour   (al_wh_ff),
        .al_min_sec   (al_ms_ff),
        .tm_month_day (time_month_day),
        .tm_wd_hour   (time_weekday_hour),
        .tm_min_sec   (time_minute_second),
        .match        (match)
    );

    // ======================================================================
    // Next-state logic
    always_comb begin
        logic       fire;
        logic [15:0] hi;
        logic [15:0] lo;
        logic       unlock;
        fire   = 1'b0;
        hi     = 16'h0000;
        lo     = 16'h0000;
        unlock = cal_ff[`BIT_WRITE_UNLOCK];
        nxt_cfg        = cfg_ff;
        nxt_cal        = cal_ff;
        nxt_al_md      = al_md_ff;
        nxt_al_wh      = al_wh_ff;
        nxt_al_ms      = al_ms_ff;
        nxt_half       = half_ff;
        nxt_event      = 1'b0;
        nxt_pulse      = pulse_ff;
        nxt_cal_apply  = 1'b0;
        nxt_cal_pulses = cal_pulses_ff;
        nxt_rdata      = 32'h0000_0000;

        // Register writes
        if (wr_access) begin
            unique case (paddr)
                `OFS_ALARM_CONFIG_REPEAT: nxt_cfg = merge(cfg_ff, pwdata[15:0], pstrb[1:0]);
                `OFS_CONFIG_CALIBRATION:  nxt_cal = merge(cal_ff, pwdata[15:0], pstrb[1:0])
                                                    & 16'hC0FF;
                `OFS_ALARM_VALUE_WINDOW: begin
                    unique case (value_ptr_e'(ptr))
                        ptr_min_sec: begin
                            nxt_al_ms = merge(al_ms_ff, {pwdata[31:24], pwdata[7:0]},
                                              {pstrb[3], pstrb[0]})
                                        & `MASK_MINUTE_SECOND;
                        end
                        ptr_wd_hour: if (unlock) begin
                            nxt_al_wh = merge(al_wh_ff, {pwdata[31:24], pwdata[7:0]},
                                              {pstrb[3], pstrb[0]})
                                        & `MASK_WEEKDAY_HOUR;
                        end
                        ptr_month_day: if (unlock) begin
                            nxt_al_md = merge(al_md_ff, {pwdata[31:24], pwdata[7:0]},
                                              {pstrb[3], pstrb[0]})
                                        & `MASK_MONTH_DAY;
                        end
                        ptr_none: ;
                    endcase
                end
                default: ;
            endcase
        end
        // High byte of the window maps minutes, weekday, month; low byte seconds, hour, day
        unique case (value_ptr_e'(ptr))
            ptr_min_sec:   begin hi = al_ms_ff; lo = al_ms_ff; end
            ptr_wd_hour:   begin hi = al_wh_ff; lo = al_wh_ff; end
            ptr_month_day: begin hi = al_md_ff; lo = al_md_ff; end
            ptr_none:      begin hi = 16'h0000; lo = 16'h0000; end
        endcase

        // Register reads
        if (rd_access) begin
            unique case (paddr)
                `OFS_ALARM_CONFIG_REPEAT: nxt_rdata = {16'h0000, cfg_ff};
                `OFS_ALARM_VALUE_WINDOW:  nxt_rdata = {hi[15:8], 16'h0000, lo[7:0]};
                `OFS_CONFIG_CALIBRATION:  nxt_rdata = {16'h0000, cal_ff};
                `OFS_TIME_MONTH_DAY:      nxt_rdata = {16'h0000, time_month_day};
                `OFS_TIME_WEEKDAY_HOUR:   nxt_rdata = {16'h0000, time_weekday_hour};
                `OFS_TIME_MINUTE_SECOND:  nxt_rdata = {16'h0000, time_minute_second};
                `OFS_STATUS:              nxt_rdata = {30'h0000_0000, pulse_ff,
                                                       rollover_window};
                default:                  nxt_rdata = 32'h0000_0000;
            endcase
        end

        // Pointer walks down after each access to the high half, stopping at zero
        if (window_high && ptr != 2'h0 && !(wr_access && paddr == `OFS_ALARM_CONFIG_REPEAT)) begin
            nxt_cfg[`POS_POINTER +: 2] = ptr - 2'h1;
        end

        // Half-second phase so that the every-second code fires on whole seconds only
        if (half_sec_tick) begin
            nxt_half = ~half_ff;
        end

        // One evaluation per tick, so a steady match fires at most once per tick rather than every cycle
        if (half_sec_tick && cfg_ff[`BIT_ALARM_ON] && match) begin
            fire = (cfg_ff[`POS_INTERVAL +: 4] == 4'h0) | half_ff;
        end

        if (fire) begin
            nxt_event = 1'b1;
            nxt_pulse = ~pulse_ff;
            if (cfg_ff[`POS_REPEAT +: 8] != 8'h00) begin
                nxt_cfg[`POS_REPEAT +: 8] = cfg_ff[`POS_REPEAT +: 8] - 8'h01;
            end else if (cfg_ff[`BIT_CHIME]) begin
                nxt_cfg[`POS_REPEAT +: 8] = 8'hFF;
            end else begin
                nxt_cfg[`BIT_ALARM_ON] = 1'b0;
            end
        end

        // Minute correction: signed byte times four, positive adds, negative removes
        if (minute_rollover && cal_ff[`BIT_TIMER_ON]) begin
            nxt_cal_apply  = 1'b1;
            nxt_cal_pulses = 11'(signed'(cal_ff[7:0])) * 11'sd4;
        end
    end

    // ======================================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff        <= `RST_CONFIG_REPEAT;
            cal_ff        <= `RST_CALIBRATION;
            al_md_ff      <= `RST_ALARM_VALUE;
            al_wh_ff      <= `RST_ALARM_VALUE;
            al_ms_ff      <= `RST_ALARM_VALUE;
            half_ff       <= 1'b0;
            event_ff      <= 1'b0;
            pulse_ff      <= 1'b0;
            cal_apply_ff  <= 1'b0;
            cal_pulses_ff <= 11'sd0;
            rdata_ff      <= 32'h0000_0000;
        end else begin
            cfg_ff        <= nxt_cfg;
            cal_ff        <= nxt_cal;
            al_md_ff      <= nxt_al_md;
            al_wh_ff      <= nxt_al_wh;
            al_ms_ff      <= nxt_al_ms;
            half_ff       <= nxt_half;
            event_ff      <= nxt_event;
            pulse_ff      <= nxt_pulse;
            cal_apply_ff  <= nxt_cal_apply;
            cal_pulses_ff <= nxt_cal_pulses;
            rdata_ff      <= nxt_rdata;
        end
    end

    // ======================================================================
    // Outputs
    assign pready      = 1'b1;
    assign pslverr     = psel & penable & ~known_addr(paddr);
    assign prdata      = rd_access ? nxt_rdata : rdata_ff;
    assign alarm_event = event_ff;
    assign alarm_pulse = pulse_ff;
    assign cal_apply   = cal_apply_ff;
    assign cal_pulses  = cal_pulses_ff;

endmodule

// file: tb/rtc_alarm_calibration_properties.sv
// Port relations of the alarm and calibration block
`timescale 1ns/1ps
module rtc_alarm_calibration_properties (
    // Clock and reset
    input wire logic               pclk,
    input wire logic               presetn,
    // APB
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    // Time base
    input wire logic               half_sec_tick,
    input wire logic               minute_rollover,
    // Results
    input wire logic               cal_apply,
    input wire logic signed [10:0] cal_pulses,
    input wire logic               alarm_event,
    input wire logic               alarm_pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Sequences
    sequence s_tick_then_evt;
        half_sec_tick ##1 alarm_event;
    endsequence
    sequence s_evt_once;
        alarm_event ##1 !alarm_event;
    endsequence
    // ==========================================================
    // Properties
    property p_ready; psel && penable |-> pready; endproperty
    property p_refuse; pslverr |-> psel && penable && prdata == 32'h0; endproperty
    property p_evt_cause; alarm_event |-> $past(half_sec_tick); endproperty
    property p_evt_single; alarm_event |-> s_evt_once; endproperty
    property p_toggle; s_tick_then_evt |-> alarm_pulse != $past(alarm_pulse); endproperty
    property p_pulse_hold; !alarm_event |-> $stable(alarm_pulse); endproperty
    property p_cal_cause; cal_apply |-> $past(minute_rollover); endproperty
    property p_cal_once; cal_apply |=> !cal_apply; endproperty
    property p_cal_step;
        cal_apply |-> cal_pulses[1:0] == 2'b00 && cal_pulses >= -512 && cal_pulses <= 508;
    endproperty
    a_ready: assert property (p_ready) else $error("access without ready");
    a_refuse: assert property (p_refuse) else $error("error response outside access");
    a_evt_cause: assert property (p_evt_cause) else $error("alarm without tick");
    a_evt_single: assert property (p_evt_single) else $error("alarm longer than one cycle");
    a_toggle: assert property (p_toggle) else $error("pulse did not toggle");
    a_pulse_hold: assert property (p_pulse_hold) else $error("pulse moved alone");
    a_cal_cause: assert property (p_cal_cause) else $error("correction off rollover");
    a_cal_once: assert property (p_cal_once) else $error("correction twice");
    a_cal_step: assert property (p_cal_step) else $error("correction not in steps of four");
endmodule

// file: tb/tb_rtc_alarm_calibration.sv
// Self-checking bench of the alarm and calibration block
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module tb_rtc_alarm_calibration;
    localparam logic [11:0] a_cfg = `OFS_ALARM_CONFIG_REPEAT;
    localparam logic [11:0] a_win = `OFS_ALARM_VALUE_WINDOW;
    localparam logic [11:0] a_cal = `OFS_CONFIG_CALIBRATION;
    logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0, prdata, rd;
    logic [3:0]         pstrb = 4'hF;
    logic               pready, pslverr, slv, cal_apply, alarm_event, alarm_pulse;
    logic               half_sec_tick = 1'b0, minute_rollover = 1'b0, rollover_window = 1'b0;
    logic [15:0]        tmd = 16'h0, twh = 16'h0, tms = 16'h0;
    logic signed [10:0] cal_pulses, ce;
    logic               pulse_m = 1'b0;
    logic [15:0]        av[3];
    logic [15:0]        mk[3] = '{`MASK_MONTH_DAY, `MASK_WEEKDAY_HOUR, `MASK_MINUTE_SECOND};
    logic [7:0]         cbv[5];
    int                 error_cnt = 0, comparisons = 0, seed = 82, events, n, k, p;
    int                 rc[3];

    always #12.5 pclk = ~pclk;

    rtc_alarm_calibration i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rtc_tick(1'b0), .half_sec_tick(half_sec_tick),
        .minute_rollover(minute_rollover), .rollover_window(rollover_window),
        .time_month_day(tmd), .time_weekday_hour(twh), .time_minute_second(tms),
        .cal_apply(cal_apply), .cal_pulses(cal_pulses), .alarm_event(alarm_event),
        .alarm_pulse(alarm_pulse)
    );

    // ==========================================================
    // Shared tasks
    task automatic end_sim();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Ready, read data and error are all taken at the edge that ends the access
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            check(32'h0, 32'h1, "ready timeout");
            end_sim();
        end
        rd  = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One-cycle time base pulse; results land in the following cycle
    task automatic tick(input bit hs);
        @(posedge pclk);
        if (hs) half_sec_tick <= 1'b1;
        else minute_rollover <= 1'b1;
        @(posedge pclk);
        half_sec_tick   <= 1'b0;
        minute_rollover <= 1'b0;
        #1;
        if (alarm_event === 1'b1) begin
            events++;
            pulse_m = !pulse_m;
        end
        check(alarm_pulse, pulse_m, "alarm pulse");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, a_cfg, 32'h0);
        check(rd, 32'h0, "config reset");
        apb(0, a_cal, 32'h0);
        check(rd, 32'h0, "calibration reset");
        apb(0, 12'h100, 32'h0);
        check({rd[30:0], slv}, 32'h1, "unmapped");
        rollover_window <= 1'b1;
        apb(0, `OFS_STATUS, 32'h0);
        check(rd[0], 1'b1, "status");
        rollover_window <= 1'b0;
        for (k = 0; k < 3; k++) av[k] = 16'($random(seed));
        apb(1, a_cfg, 32'h0200);
        apb(1, a_win, {av[0][15:8], 16'h0, av[0][7:0]});
        apb(1, a_cfg, 32'h0200);
        apb(0, a_win, 32'h0);
        check(rd, 32'h0, "locked write");
        apb(1, a_cal, 32'h8000);
        apb(1, a_cfg, 32'h0200);
        for (k = 0; k < 3; k++) apb(1, a_win, {av[k][15:8], 16'h0, av[k][7:0]});
        apb(0, a_cfg, 32'h0);
        check(rd, 32'h0, "pointer at zero");
        apb(1, a_cfg, 32'h0200);
        for (k = 0; k < 3; k++) begin
            av[k] = av[k] & mk[k];
            apb(0, a_win, 32'h0);
            check(rd, {av[k][15:8], 16'h0, av[k][7:0]}, "window");
        end
        tmd <= av[0];
        twh <= av[1];
        tms <= av[2];
        rc = '{0, 0, 255};
        rc[1] = $random(seed) & 7;
        foreach (rc[j]) begin
            apb(1, a_cfg, 32'h8000 | rc[j]);
            events = 0;
            repeat (rc[j] + 3) tick(1);
            check(events, rc[j] + 1, "repeat count");
            apb(0, a_cfg, 32'h0);
            check(rd, 32'h0, "alarm off");
        end
        apb(1, a_cfg, 32'hC001);
        events = 0;
        repeat (3) tick(1);
        check(events, 3, "chime events");
        apb(0, a_cfg, 32'h0);
        check(rd, 32'hC0FE, "chime wrap");
        // Second pass breaks the seconds ones digit, so only maskless codes may fire
        for (p = 0; p < 2; p++) begin
            apb(1, a_cfg, 32'h0);
            tms <= av[2] ^ 16'(p);
            for (k = 0; k < 16; k++) begin
                apb(1, a_cfg, 32'h8000 | (k << 10));
                events = 0;
                repeat (2) tick(1);
                n = (k < 2 || (k <= 9 && p == 0)) ? 1 : 0;
                check(events, n, "interval");
                apb(0, a_cfg, 32'h0);
                check(rd, (n ? 32'h0 : 32'h8000) | (k << 10), "interval config");
            end
        end
        cbv = '{8'h80, 8'h7F, 8'hFF, 8'h01, 8'h00};
        cbv[4] = 8'($random(seed));
        foreach (cbv[j]) begin
            tick(1);
            apb(1, a_cal, {16'h0, 8'h40, cbv[j]});
            tick(0);
            ce = {cbv[j][7], cbv[j], 2'b00};
            check(cal_apply, 1'b1, "correction");
            check(cal_pulses, ce, "correction size");
        end
        tick(1);
        apb(1, a_cal, 32'h0005);
        tick(0);
        check(cal_apply, 1'b0, "timer off");
        end_sim();
    end
endmodule

bind rtc_alarm_calibration rtc_alarm_calibration_properties i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .half_sec_tick(half_sec_tick),
    .minute_rollover(minute_rollover), .cal_apply(cal_apply), .cal_pulses(cal_pulses),
    .alarm_event(alarm_event), .alarm_pulse(alarm_pulse)
);
